// ===== soi_interlock.sv
// What this block does
// - After a field interruption outputs stay off until a valid reset.
// - An accepted reset switches the safety outputs on.
// - Feedback monitoring is chosen only by a wiring input sampled once.
// - With monitoring, feedback loop must be closed before every switch-on.
// - After switch-on the loop must open within 500 ms, else fault.
// - After switch-off the loop must close within 500 ms, else fault.
// - A switch-on contactor fault drives the briefly enabled outputs back off.
// - A contactor fault shows one of two external fault codes.
// - After a contactor fault, lock-out with outputs off until power cycle.
// - By default the device runs on transmission channel one.
// - Supply polarity selects between the two transmission channels.
// - In normal operation the display shows the selected channel number.
// - Reduced-range wiring lowers emitted light power to about half range.
// - Range reduction is unmonitored and feeds no safety decision.
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
module soi_interlock
  import soi_pkg::*;
#(
  parameter int unsigned RST_MIN = RST_MIN_CYC,
  parameter int unsigned RST_MAX = RST_MAX_CYC,
  parameter int unsigned FB_WIN = FB_WIN_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic field_clear_i,
  input wire logic reset_btn_i,
  input wire logic supply_pol_i,
  input wire logic fb_mon_en_i,
  input wire logic range_reduce_i,
  input wire logic fb_loop_closed_i,
  output logic safety_switch_output_o,
  output logic tx_power_reduced_o,
  output logic channel_two_o,
  output logic [DISP_W-1:0] seg_code_o,
  output logic irq_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int BW = $clog2(RST_MAX + 2);
  localparam int FW = $clog2(FB_WIN + 1);

  soi_state_type state_r;
  soi_state_type state_nxt;
  logic out_r;
  logic [DISP_W-1:0] disp_r;
  logic [DISP_W-1:0] disp_nxt;
  logic cfg_taken_r;
  logic mon_en_r;
  logic ch_two_r;
  logic range_r;
  logic btn_q_r;
  logic [EV_W-1:0] irq_stat_r;
  logic [EV_W-1:0] irq_mask_r;
  logic [EV_W-1:0] ev;

  // Bus slave storage
  logic aw_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic w_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Timer outputs
  logic [BW-1:0] btn_cnt;
  logic btn_sat;
  logic [FW-1:0] fb_cnt;
  logic fb_sat;

  // Button hold measurement, cleared whenever the button is up
  soi_run_counter #(
    .LIMIT(RST_MAX + 1),
    .W(BW)
  ) u_btn_cnt (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(clk_en_i),
    .clear_i(!reset_btn_i),
    .run_i(reset_btn_i),
    .cnt_o(btn_cnt),
    .sat_o(btn_sat)
  );

  // Feedback window timer, restarted on every state transition
  wire state_chg = (state_nxt != state_r);
  wire in_chk = (state_r == ST_ON_CHK) || (state_r == ST_OFF_CHK);

  soi_run_counter #(
    .LIMIT(FB_WIN),
    .W(FW)
  ) u_fb_cnt (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(clk_en_i),
    .clear_i(state_chg),
    .run_i(in_chk),
    .cnt_o(fb_cnt),
    .sat_o(fb_sat)
  );

  // Reset actuation decode: judged on the release edge
  wire btn_release = btn_q_r && !reset_btn_i;
  wire hold_ok = (btn_cnt >= BW'(RST_MIN)) && (btn_cnt <= BW'(RST_MAX));
  wire reset_valid = btn_release && hold_ok && field_clear_i;
  wire reset_bad = btn_release && !reset_valid && (state_r == ST_LOCK);
  wire loop_ready = !mon_en_r || fb_loop_closed_i;

  // Interlock state machine
  always_comb begin
    state_nxt = state_r;
    ev = '0;
    ev[EV_REJECT] = reset_bad;
    unique case (state_r)
      ST_LOCK: begin
        if (cfg_taken_r && reset_valid) begin
          ev[EV_ACCEPT] = 1'b1;
          if (loop_ready) begin
            ev[EV_ON] = 1'b1;
            state_nxt = mon_en_r ? ST_ON_CHK : ST_ON;
          end else begin
            ev[EV_REJECT] = 1'b1;
          end
        end
      end
      ST_ON_CHK: begin
        if (!field_clear_i) begin
          ev[EV_OFF] = 1'b1;
          state_nxt = ST_OFF_CHK;
        end else if (!fb_loop_closed_i) begin
          state_nxt = ST_ON;
        end else if (fb_sat) begin
          ev[EV_FAULT_A] = 1'b1;
          state_nxt = ST_FAULT;
        end
      end
      ST_ON: begin
        if (!field_clear_i) begin
          ev[EV_OFF] = 1'b1;
          state_nxt = mon_en_r ? ST_OFF_CHK : ST_LOCK;
        end
      end
      ST_OFF_CHK: begin
        if (fb_loop_closed_i) begin
          state_nxt = ST_LOCK;
        end else if (fb_sat) begin
          ev[EV_FAULT_B] = 1'b1;
          state_nxt = ST_FAULT;
        end
      end
      ST_FAULT: begin
        state_nxt = ST_FAULT;
      end
      default: begin
        state_nxt = ST_FAULT;
      end
    endcase
  end

  // Display: fault codes win, otherwise the selected channel
  always_comb begin
    disp_nxt = ch_two_r ? DISP_CHANNEL_TWO : DISP_CHANNEL_ONE;
    if (!cfg_taken_r) begin
      disp_nxt = DISP_BLANK;
    end else if (ev[EV_FAULT_A]) begin
      disp_nxt = DISP_FEEDBACK_FAULT_CODE_A;
    end else if (ev[EV_FAULT_B]) begin
      disp_nxt = DISP_FEEDBACK_FAULT_CODE_B;
    end else if (state_r == ST_FAULT) begin
      disp_nxt = disp_r;
    end
  end

  // Output is a flop of the next state, so it drops in the fault cycle
  wire out_nxt = (state_nxt == ST_ON_CHK) || (state_nxt == ST_ON);

  // Main state and outputs
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_LOCK;
      out_r <= 1'b0;
      disp_r <= DISP_BLANK;
      btn_q_r <= 1'b0;
    end else if (clk_en_i) begin
      state_r <= cfg_taken_r ? state_nxt : ST_LOCK;
      out_r <= cfg_taken_r && out_nxt;
      disp_r <= disp_nxt;
      btn_q_r <= reset_btn_i;
    end
  end

  // Wiring straps caught once after reset release; later changes need a power cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_taken_r <= 1'b0;
      mon_en_r <= 1'b0;
      ch_two_r <= 1'b0;
    end else if (clk_en_i && !cfg_taken_r) begin
      cfg_taken_r <= 1'b1;
      mon_en_r <= fb_mon_en_i;
      ch_two_r <= supply_pol_i;
    end
  end

  // Range option only sets light power and a status bit; no interlock decision reads it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      range_r <= 1'b0;
    end else if (clk_en_i) begin
      range_r <= range_reduce_i;
    end
  end

  assign safety_switch_output_o = out_r;
  assign tx_power_reduced_o = range_r;
  assign channel_two_o = ch_two_r;
  assign seg_code_o = disp_r;

  // Write channel: address and data taken in either order, held until both
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_do = aw_held_r && w_held_r && !bvalid_r && clk_en_i;
  assign s_axi_awready = !aw_held_r && clk_en_i;
  assign s_axi_wready = !w_held_r && clk_en_i;

  // Write decode; only byte lane 0 carries writable bits
  wire wr_stat = wr_do && (awaddr_r == ADDR_IRQ_STAT);
  wire wr_mask = wr_do && (awaddr_r == ADDR_IRQ_MASK);
  wire wr_ro = (awaddr_r == ADDR_STATUS) || (awaddr_r == ADDR_DISPLAY);
  wire wr_mapped = (awaddr_r == ADDR_IRQ_STAT) || (awaddr_r == ADDR_IRQ_MASK) || wr_ro;
  wire [EV_W-1:0] stat_clr = (wr_stat && wstrb_r[0]) ? wdata_r[EV_W-1:0] : '0;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (clk_en_i) begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_held_r <= 1'b0;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_do) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (clk_en_i) begin
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Sticky events: a new event wins over a clear in the same cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_r <= '0;
      irq_mask_r <= IRQ_MASK_RST;
    end else if (clk_en_i) begin
      irq_stat_r <= (irq_stat_r & ~stat_clr) | ev;
      if (wr_mask && wstrb_r[0]) begin
        irq_mask_r <= wdata_r[EV_W-1:0];
      end
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  // Read decode
  wire [31:0] status_word = (32'h0000_0000
    | (32'(state_r) << ST_STATE_LSB)
    | (32'(out_r) << ST_OUT_BIT)
    | (32'(mon_en_r) << ST_MON_BIT)
    | (32'(ch_two_r) << ST_CH2_BIT)
    | (32'(range_r) << ST_RANGE_BIT)
    | (32'(cfg_taken_r) << ST_CFG_BIT));
  wire rd_status = (s_axi_araddr == ADDR_STATUS);
  wire rd_stat = (s_axi_araddr == ADDR_IRQ_STAT);
  wire rd_mask = (s_axi_araddr == ADDR_IRQ_MASK);
  wire rd_disp = (s_axi_araddr == ADDR_DISPLAY);
  wire rd_mapped = rd_status || rd_stat || rd_mask || rd_disp;
  wire [31:0] rd_mux = rd_status ? status_word
    : rd_stat ? 32'(irq_stat_r)
    : rd_mask ? 32'(irq_mask_r)
    : rd_disp ? 32'(disp_r)
    : 32'h0000_0000;

  // Read channel: one read at a time, answer one cycle after the address
  assign s_axi_arready = !rvalid_r && clk_en_i;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (clk_en_i) begin
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule : soi_interlock

// ===== soi_pkg.sv
package soi_pkg;

  // Clock rate and documented times, each in its own unit
  localparam int CLK_MHZ = 100;
  localparam int T_RST_MIN_US = 150000;
  localparam int T_RST_MAX_US = 4000000;
  localparam int T_FB_WIN_US = 500000;

  // Derived cycle counts: exact at 100 MHz, so no rounding is lost
  localparam int RST_MIN_CYC = T_RST_MIN_US * CLK_MHZ;
  localparam int RST_MAX_CYC = T_RST_MAX_US * CLK_MHZ;
  localparam int FB_WIN_CYC = T_FB_WIN_US * CLK_MHZ;

  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [7:0] ADDR_DISPLAY = 8'h0C;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Event bits shared by status and mask registers
  localparam int EV_W = 6;
  localparam int EV_ACCEPT = 0;
  localparam int EV_ON = 1;
  localparam int EV_OFF = 2;
  localparam int EV_FAULT_A = 3;
  localparam int EV_FAULT_B = 4;
  localparam int EV_REJECT = 5;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 6'h00;

  // Status register field positions
  localparam int ST_STATE_LSB = 0;
  localparam int ST_OUT_BIT = 8;
  localparam int ST_MON_BIT = 9;
  localparam int ST_CH2_BIT = 10;
  localparam int ST_RANGE_BIT = 11;
  localparam int ST_CFG_BIT = 12;

  // Display codes
  localparam int DISP_W = 8;
  localparam logic [7:0] DISP_BLANK = 8'h00;
  localparam logic [7:0] DISP_CHANNEL_ONE = 8'h01;
  localparam logic [7:0] DISP_CHANNEL_TWO = 8'h02;
  localparam logic [7:0] DISP_FEEDBACK_FAULT_CODE_A = 8'h30;
  localparam logic [7:0] DISP_FEEDBACK_FAULT_CODE_B = 8'h31;

  // Interlock states, one-hot
  typedef enum logic [4:0] {
    ST_LOCK = 5'h01,
    ST_ON_CHK = 5'h02,
    ST_ON = 5'h04,
    ST_OFF_CHK = 5'h08,
    ST_FAULT = 5'h10
  } soi_state_type;

endpackage : soi_pkg

// ===== soi_run_counter.sv
`timescale 1ns/1ns
module soi_run_counter #(
  parameter int unsigned LIMIT = 16,
  parameter int W = $clog2(LIMIT + 1)
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic run_i,
  output logic [W-1:0] cnt_o,
  output logic sat_o
);

  logic [W-1:0] cnt_r;

  // Saturating count; clear has priority so a restart is never missed
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else if (ce_i) begin
      if (clear_i) begin
        cnt_r <= '0;
      end else if (run_i && !sat_o) begin
        cnt_r <= cnt_r + W'(1);
      end
    end
  end

  assign cnt_o = cnt_r;
  assign sat_o = (cnt_r == W'(LIMIT));

endmodule : soi_run_counter

// ===== soi_contactor.sv
`timescale 1ns/1ns
module soi_contactor (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic coil_i,
  input wire logic stuck_i,
  input wire logic broken_i,
  input wire logic [7:0] lag_i,
  output logic fb_loop_closed_o
);
  logic shut_r;
  int cnt_r;
  // Feedback contact is normally closed, so it opens while the coil pulls in
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shut_r <= 1'b1;
      cnt_r <= 0;
    end else if (stuck_i || shut_r != coil_i) begin
      cnt_r <= 0; // Welded contact never follows the coil
    end else if (cnt_r >= int'(lag_i)) begin
      shut_r <= !coil_i;
      cnt_r <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  // A broken wire reads as an open loop whatever the contact does
  assign fb_loop_closed_o = shut_r && !broken_i;
endmodule : soi_contactor

// ===== soi_interlock_assertions.sv
`timescale 1ns/1ns
module soi_interlock_checker
  import soi_pkg::*;
#(
  parameter int unsigned FB_WIN = FB_WIN_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic field_clear_i,
  input wire logic reset_btn_i,
  input wire logic fb_mon_en_i,
  input wire logic range_reduce_i,
  input wire logic fb_loop_closed_i,
  input wire logic safety_switch_output_o,
  input wire logic tx_power_reduced_o,
  input wire logic channel_two_o,
  input wire logic [DISP_W-1:0] seg_code_o,
  input wire logic s_axi_awready,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  int on_cnt_r;
  int off_cnt_r;
  logic pend_r;
  wire flt = seg_code_o == DISP_FEEDBACK_FAULT_CODE_A || seg_code_o == DISP_FEEDBACK_FAULT_CODE_B;
  // Time the loop stays shut with outputs on, and open after they drop
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_cnt_r <= 0;
      off_cnt_r <= 0;
      pend_r <= 1'b0;
    end else begin
      on_cnt_r <= (safety_switch_output_o && fb_loop_closed_i && fb_mon_en_i) ? on_cnt_r + 1 : 0;
      pend_r <= fb_mon_en_i && ($fell(safety_switch_output_o) || (pend_r && !fb_loop_closed_i && !flt));
      off_cnt_r <= pend_r ? off_cnt_r + 1 : 0;
    end
  end
  a_field_drop_off: assert property (safety_switch_output_o && !field_clear_i && clk_en_i |=>
    !safety_switch_output_o) else $error("output stayed on with field blocked");
  a_rise_on_release: assert property ($rose(safety_switch_output_o) |->
    $past(field_clear_i) && !$past(reset_btn_i)) else $error("output rose without release");
  a_loop_before_on: assert property ($rose(safety_switch_output_o) && fb_mon_en_i |->
    $past(fb_loop_closed_i)) else $error("output rose with loop open");
  a_open_window: assert property (on_cnt_r <= FB_WIN + 4) else $error("loop shut too long");
  a_close_window: assert property (off_cnt_r <= FB_WIN + 4) else $error("loop open too long");
  a_fault_hold: assert property (flt |=> !safety_switch_output_o && $stable(seg_code_o))
    else $error("fault lock-out left");
  a_chan_disp: assert property ((seg_code_o == DISP_CHANNEL_ONE || seg_code_o == DISP_CHANNEL_TWO) |->
    channel_two_o == (seg_code_o == DISP_CHANNEL_TWO)) else $error("display and channel differ");
  a_range_copy: assert property (rst_n_i && clk_en_i |=> tx_power_reduced_o == $past(range_reduce_i))
    else $error("range copy wrong");
  a_gate_ready: assert property (!clk_en_i |-> !s_axi_awready && !s_axi_arready) else $error("ready while frozen");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule : soi_interlock_checker
bind soi_interlock soi_interlock_checker #(.FB_WIN(FB_WIN)) u_chk (.mclk_i, .rst_n_i, .clk_en_i,
  .field_clear_i, .reset_btn_i, .fb_mon_en_i, .range_reduce_i, .fb_loop_closed_i, .safety_switch_output_o,
  .tx_power_reduced_o, .channel_two_o, .seg_code_o, .s_axi_awready, .s_axi_arready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready);

// ===== safety_output_interlock_test.sv
`timescale 1ns/1ns
module safety_output_interlock_test;
  import soi_pkg::*;
  localparam int FBW = 20;
  logic mclk_i = 0, rst_n_i = 0, clk_en_i = 1, field_clear_i = 1, reset_btn_i = 0, supply_pol_i = 0;
  logic fb_mon_en_i = 1, range_reduce_i = 0, stuck = 0, broken = 0, fb_loop_closed_i, faulted = 0;
  logic safety_switch_output_o, tx_power_reduced_o, channel_two_o, irq_o;
  logic [7:0] seg_code_o, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rnd = 8'h50, lag = 8'h03;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int failures = 0, samples_checked = 0, cycles = 0;
  soi_interlock #(.RST_MIN(10), .RST_MAX(40), .FB_WIN(FBW)) DUT (.*);
  soi_contactor PM (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .coil_i(safety_switch_output_o), .stuck_i(stuck),
    .broken_i(broken), .lag_i(lag), .fb_loop_closed_o(fb_loop_closed_i));
  always #5 mclk_i = ~mclk_i;
  // A hang is cut short well after the longest sequence should have ended
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures = failures + 1;
      tally_and_finish();
    end
  end
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nx
  task automatic tally_and_finish;
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Handshakes are judged at the falling edge, where ready and valid are settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, bh;
    bh = 0;
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!bh) begin
      @(negedge mclk_i);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid && s_axi_bready;
      if (bh) check(s_axi_bresp, er);
      @(posedge mclk_i);
      if (ah) s_axi_awvalid <= 0;
      if (wh) s_axi_wvalid <= 0;
      if (bh) s_axi_bready <= 0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    logic ah, rh;
    rh = 0;
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!rh) begin
      @(negedge mclk_i);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid && s_axi_rready;
      if (rh) check(s_axi_rdata & m, e);
      if (rh) check(s_axi_rresp, er);
      @(posedge mclk_i);
      if (ah) s_axi_arvalid <= 0;
      if (rh) s_axi_rready <= 0;
    end
  endtask : rd
  // Model: a hold inside the window, field free, loop shut if watched, no lock-out
  // Expectation is taken after the edge, so a strap set just before the call is already seen
  task automatic press(input int n);
    logic exp;
    @(posedge mclk_i);
    exp = !faulted && n >= 10 && n <= 40 && field_clear_i && (!fb_mon_en_i || fb_loop_closed_i);
    reset_btn_i <= 1;
    repeat (n) @(posedge mclk_i);
    reset_btn_i <= 0;
    repeat (4) @(negedge mclk_i);
    check(safety_switch_output_o, exp);
    @(posedge mclk_i); // Caller's next drives then land on a rising edge
  endtask : press
  task automatic power_cycle(input logic pol, input logic mon);
    @(posedge mclk_i);
    rst_n_i <= 0;
    supply_pol_i <= pol;
    fb_mon_en_i <= mon;
    stuck <= 0;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1;
    faulted = 0;
    repeat (3) @(negedge mclk_i);
    check(seg_code_o, pol ? DISP_CHANNEL_TWO : DISP_CHANNEL_ONE);
    check(channel_two_o, pol);
  endtask : power_cycle
  initial begin
    power_cycle(1'b0, 1'b1);
    rd(ADDR_STATUS, 32'h1F1F, 32'h1201, RESP_OKAY);
    clk_en_i <= 0;
    repeat (3) @(posedge mclk_i);
    clk_en_i <= 1;
    // Random range straps: only the light power copy and its status bit may follow them
    repeat (4) begin
      rnd = nx(rnd);
      range_reduce_i <= rnd[0];
      repeat (2) @(negedge mclk_i);
      check(tx_power_reduced_o, rnd[0]);
      @(posedge mclk_i);
    end
    wr(ADDR_IRQ_MASK, 32'h3F, RESP_OKAY);
    rd(ADDR_IRQ_MASK, 32'h3F, 32'h3F, RESP_OKAY);
    press(5);
    rd(ADDR_IRQ_STAT, 32'h20, 32'h20, RESP_OKAY);
    @(negedge mclk_i);
    check(irq_o, 1'b1);
    wr(ADDR_IRQ_STAT, 32'h3F, RESP_OKAY);
    @(negedge mclk_i);
    check(irq_o, 1'b0);
    wr(8'h40, 32'h0, RESP_SLVERR);
    rd(8'h40, 32'h0, 32'h0, RESP_SLVERR);
    press(45);
    field_clear_i <= 0;
    press(20);
    field_clear_i <= 1;
    broken <= 1;
    press(20);
    broken <= 0;
    rnd = nx(rnd);
    lag <= {4'h0, rnd[3:0]};
    press(12 + int'(rnd) % 28);
    repeat (FBW) @(posedge mclk_i);
    field_clear_i <= 0;
    repeat (2) @(negedge mclk_i);
    check(safety_switch_output_o, 1'b0);
    @(posedge mclk_i);
    field_clear_i <= 1;
    repeat (FBW + 6) @(negedge mclk_i);
    check(safety_switch_output_o, 1'b0);
    rd(ADDR_STATUS, 32'h1F, 32'h01, RESP_OKAY);
    stuck <= 1;
    press(20);
    repeat (FBW + 8) @(negedge mclk_i);
    check(safety_switch_output_o, 1'b0);
    check(seg_code_o, DISP_FEEDBACK_FAULT_CODE_A);
    faulted = 1;
    stuck <= 0;
    press(20);
    rd(ADDR_STATUS, 32'h1F, 32'h10, RESP_OKAY);
    power_cycle(1'b1, 1'b1);
    lag <= 8'h02;
    press(20);
    repeat (FBW / 2) @(posedge mclk_i);
    stuck <= 1;
    field_clear_i <= 0;
    repeat (FBW + 8) @(negedge mclk_i);
    check(seg_code_o, DISP_FEEDBACK_FAULT_CODE_B);
    @(posedge mclk_i);
    field_clear_i <= 1;
    power_cycle(1'b1, 1'b0);
    broken <= 1;
    press(20);
    tally_and_finish();
  end
endmodule : safety_output_interlock_test
